// >>> cml_pkg.sv
// Purpose: Constants and types shared by the console mode control logic.
// Assumes: One 100 MHz clock, APB register access, 8-bit pot codes.
// Notes: Switch fields live in the control register.
// What this block does
// RL1: Reversed sides with level/level lets the left pot set the right gain.
// RL2: Normal sides with level/balance favours left as balance goes CCW.
// RL3: Reversed sides with level/balance favours right as balance goes CCW.
// RL4: The floor option clamps each gain at 40 dB below maximum, never mute.
// RL5: Full mute with level/level mutes a channel whose pot is fully CCW.
// RL6: Full mute with level/balance mutes both when the level pot is at CCW.
// RL7: Full mute with level/balance mutes the channel the balance end kills.
// RL8: The source switch routes preamp or compressor to the main output.
// RL9: In on-air mode the main output is muted while any talkback is active.
// RL10: In on-air mode the main output indicators follow the effective main output state.
// RL11: In production mode talkback never mutes the main output.
// RL12: After power-up the four indicators light in turn before running.
// RL13: Switch changes take effect at once, with no reset needed.
// RL14: With level/balance the left pot sets level, the right pot balance.
// RL15: Normal sides with level/level lets each pot set its own channel.
// RL16: Pot codes are digital; lowest and highest codes are the ends.
package cml_pkg;
   localparam int          APB_AW        = 12;
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_GAIN     = 12'h008;
   localparam int          CTRL_MAP_BIT  = 0;
   localparam int          CTRL_REV_BIT  = 1;
   localparam int          CTRL_MIN_BIT  = 2;
   localparam int          CTRL_SRC_BIT  = 3;
   localparam int          CTRL_SYS_BIT  = 4;
   localparam int          CTRL_W        = 5;
   localparam logic [4:0]  CTRL_RESET    = 5'h00;
   localparam int          ST_MUTE_L     = 0;
   localparam int          ST_MUTE_R     = 1;
   localparam int          ST_MAIN_ACT   = 2;
   localparam int          ST_BOOT_DONE  = 3;
   localparam int          ST_LED_LSB    = 4;
   localparam int          GAIN_L_LSB    = 0;
   localparam int          GAIN_R_LSB    = 8;
   localparam logic [7:0]  POT_MIN       = 8'h00;
   localparam logic [7:0]  POT_MAX       = 8'hff;
   localparam logic [7:0]  BAL_MID       = 8'h80;
   localparam logic [8:0]  BAL_UNITY     = 9'h100;
   localparam int          SCALE_SHIFT   = 8;
   localparam int          MIN_LEVEL_DB  = 40;
   localparam int          FLOOR_RATIO   = 100;
   localparam logic [7:0]  GAIN_FLOOR    =
      8'((255 + FLOOR_RATIO - 1) / FLOOR_RATIO);
   localparam int          LED_RED       = 0;
   localparam int          LED_GREEN     = 1;
   localparam int          LED_TB1       = 2;
   localparam int          LED_TB2       = 3;
   localparam int          LED_N         = 4;
   localparam logic [3:0]  LED_FIRST     = 4'h1;
   localparam int          BOOT_STEP_MS  = 250;
   localparam int          CLK_KHZ       = 100000;
   localparam int          BOOT_STEP_DFLT = BOOT_STEP_MS * CLK_KHZ;
   typedef enum logic [2:0] {
      BOOT_LED0,
      BOOT_LED1,
      BOOT_LED2,
      BOOT_LED3,
      BOOT_RUN
   } cml_boot_t;
endpackage : cml_pkg

// >>> cml_hp_map.sv
// Purpose: Maps the two headphone pots onto left and right gain and mute.
// Assumes: Pot codes are synchronous; gain 8'hff is maximum.
// Notes: Outputs are registered one cycle after the inputs.
`timescale 1ns/1ns
module cml_hp_map
   import cml_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       map_balance,
   input  wire logic       side_reverse,
   input  wire logic       full_mute,
   input  wire logic [7:0] pot_left,
   input  wire logic [7:0] pot_right,
   output logic      [7:0] hp_left_gain,
   output logic      [7:0] hp_right_gain,
   output logic            hp_left_mute,
   output logic            hp_right_mute
);
   logic [7:0] gl_nxt;
   logic [7:0] gr_nxt;
   logic       ml_nxt;
   logic       mr_nxt;
   logic [7:0] ga;
   logic [7:0] gb;
   logic       ma;
   logic       mb;

   // Unity up to mid travel, then a linear fade to zero at the far end.
   function automatic logic [8:0] bal_scale(input logic [7:0] x);
      if (x <= BAL_MID) begin
         return BAL_UNITY;
      end
      return {POT_MAX - x, 1'b0};
   endfunction : bal_scale

   function automatic logic [7:0] apply(input logic [7:0] lvl,
                                        input logic [8:0] s);
      logic [16:0] p;
      p = lvl * s;
      return p[SCALE_SHIFT +: 8];
   endfunction : apply

   function automatic logic [7:0] clamp(input logic [7:0] g,
                                        input logic       on);
      return (on && g < GAIN_FLOOR) ? GAIN_FLOOR : g;
   endfunction : clamp

   always_comb begin
      ga = apply(pot_left, bal_scale(pot_right)); // RL14
      gb = apply(pot_left, bal_scale(~pot_right));
      ma = (pot_left == POT_MIN) || (pot_right == POT_MAX); // RL6 RL7 RL16
      mb = (pot_left == POT_MIN) || (pot_right == POT_MIN); // RL6 RL7 RL16
      if (map_balance) begin
         if (side_reverse) begin
            gl_nxt = gb; // RL3
            gr_nxt = ga;
            ml_nxt = mb;
            mr_nxt = ma;
         end else begin
            gl_nxt = ga; // RL2
            gr_nxt = gb;
            ml_nxt = ma;
            mr_nxt = mb;
         end
      end else begin
         gl_nxt = side_reverse ? pot_right : pot_left; // RL1 RL15
         gr_nxt = side_reverse ? pot_left : pot_right; // RL1 RL15
         ml_nxt = gl_nxt == POT_MIN; // RL5
         mr_nxt = gr_nxt == POT_MIN; // RL5
      end
      gl_nxt = clamp(gl_nxt, !full_mute); // RL4
      gr_nxt = clamp(gr_nxt, !full_mute); // RL4
      ml_nxt = ml_nxt && full_mute; // RL4
      mr_nxt = mr_nxt && full_mute;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hp_left_gain  <= GAIN_FLOOR;
         hp_right_gain <= GAIN_FLOOR;
         hp_left_mute  <= 1'b0;
         hp_right_mute <= 1'b0;
      end else begin
         hp_left_gain  <= gl_nxt;
         hp_right_gain <= gr_nxt;
         hp_left_mute  <= ml_nxt;
         hp_right_mute <= mr_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_floor_no_mute: assert property (!full_mute |=> // RL4
      !hp_left_mute && !hp_right_mute && hp_left_gain >= GAIN_FLOOR
      && hp_right_gain >= GAIN_FLOOR)
      else $error("Floor option let a channel drop or mute.");
   a_ll_end_mute: assert property (full_mute && !map_balance && // RL5
      pot_left == POT_MIN |=>
      ($past(side_reverse) ? hp_right_mute : hp_left_mute))
      else $error("Level pot at CCW end did not mute its channel.");
   a_lb_level_mute: assert property (full_mute && map_balance && // RL6
      pot_left == POT_MIN |=> hp_left_mute && hp_right_mute)
      else $error("Level at CCW end did not mute both channels.");
   a_lb_bal_mute: assert property (full_mute && map_balance && // RL7
      pot_right == POT_MAX && pot_left != POT_MIN |=>
      ($past(side_reverse) ? hp_right_mute && !hp_left_mute
                           : hp_left_mute && !hp_right_mute))
      else $error("Balance at CW end muted the wrong channel.");
   a_rev_ll_swap: assert property (full_mute && !map_balance && // RL1
      side_reverse |=> hp_right_gain == $past(pot_left)
      && hp_left_gain == $past(pot_right))
      else $error("Reversed level/level did not swap the pots.");
   a_bal_ccw_side: assert property (map_balance && // RL2 RL3
      pot_left == POT_MAX && pot_right < BAL_MID - 8'h01 |=>
      ($past(side_reverse) ? hp_right_gain > hp_left_gain
                           : hp_left_gain > hp_right_gain))
      else $error("Balance toward CCW favoured the wrong side.");
   a_bal_centre: assert property (map_balance && // RL14
      pot_right == BAL_MID |=> hp_left_gain == hp_right_gain)
      else $error("Centred balance gave unequal gains.");
endmodule : cml_hp_map

// >>> cml_console_ctrl.sv
// Purpose: Console mode control with APB switch register and boot show.
// Assumes: Button logic upstream gives main_request; talkback levels given.
// Notes: pready is always high, so each APB access lasts one cycle.
`timescale 1ns/1ns
module cml_console_ctrl
   import cml_pkg::*;
#(
   parameter int BOOT_STEP_CYC = BOOT_STEP_DFLT
)
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [APB_AW-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic [7:0]        pot_left_code,
   input  wire logic [7:0]        pot_right_code,
   input  wire logic              main_request,
   input  wire logic              tb1_active,
   input  wire logic              tb2_active,
   output logic      [7:0]        hp_left_gain,
   output logic      [7:0]        hp_right_gain,
   output logic                   hp_left_mute,
   output logic                   hp_right_mute,
   output logic                   main_source_sel,
   output logic                   main_mute,
   output logic                   led_main_red,
   output logic                   led_main_green,
   output logic                   led_tb1,
   output logic                   led_tb2
);
   logic [CTRL_W-1:0] ctrl_r;
   logic [CTRL_W-1:0] ctrl_nxt;
   logic [31:0]       prdata_r;
   logic [31:0]       prdata_nxt;
   logic              apb_setup;
   logic              apb_access;
   logic              apb_wr_ctrl;
   logic              hp_map_select_switch;
   logic              hp_side_reverse_switch;
   logic              hp_min_level_switch;
   logic              main_source_switch;
   logic              system_mode_switch;
   cml_boot_t         boot_r;
   cml_boot_t         boot_nxt;
   logic [31:0]       step_cnt_r;
   logic [31:0]       step_cnt_nxt;
   logic              step_en;
   logic              boot_done;
   logic              talk_any;
   logic              main_act_nxt;
   logic              main_mute_r;
   logic              main_mute_nxt;
   logic              src_sel_r;
   logic              src_sel_nxt;
   logic [LED_N-1:0]  led_r;
   logic [LED_N-1:0]  led_nxt;

   function automatic logic addr_hit(input logic [APB_AW-1:0] a);
      return a == ADDR_CTRL || a == ADDR_STATUS || a == ADDR_GAIN;
   endfunction : addr_hit

   function automatic logic [LED_N-1:0] boot_leds(input cml_boot_t s);
      case (s)
         BOOT_LED0: return LED_FIRST;
         BOOT_LED1: return LED_FIRST << 1;
         BOOT_LED2: return LED_FIRST << 2;
         BOOT_LED3: return LED_FIRST << 3;
         default:   return '0;
      endcase
   endfunction : boot_leds

   assign hp_map_select_switch   = ctrl_r[CTRL_MAP_BIT];
   assign hp_side_reverse_switch = ctrl_r[CTRL_REV_BIT];
   assign hp_min_level_switch    = ctrl_r[CTRL_MIN_BIT];
   assign main_source_switch     = ctrl_r[CTRL_SRC_BIT];
   assign system_mode_switch     = ctrl_r[CTRL_SYS_BIT];

   assign apb_setup   = psel && !penable;
   assign apb_access  = psel && penable;
   assign apb_wr_ctrl = apb_access && pwrite && paddr == ADDR_CTRL
                        && pstrb[0];
   // No wait states: reads are captured in the setup cycle.
   assign pready  = 1'b1;
   assign pslverr = apb_access && !addr_hit(paddr);
   assign prdata  = prdata_r;

   // Register file and read capture.
   always_comb begin
      ctrl_nxt   = ctrl_r;
      prdata_nxt = prdata_r;
      if (apb_wr_ctrl) begin
         ctrl_nxt = pwdata[CTRL_W-1:0]; // RL13
      end
      if (apb_setup) begin
         prdata_nxt = '0;
         case (paddr)
            ADDR_CTRL: begin
               prdata_nxt[CTRL_W-1:0] = ctrl_r;
            end
            ADDR_STATUS: begin
               prdata_nxt[ST_MUTE_L]    = hp_left_mute;
               prdata_nxt[ST_MUTE_R]    = hp_right_mute;
               prdata_nxt[ST_MAIN_ACT]  = !main_mute_r;
               prdata_nxt[ST_BOOT_DONE] = boot_done;
               prdata_nxt[ST_LED_LSB +: LED_N] = led_r;
            end
            ADDR_GAIN: begin
               prdata_nxt[GAIN_L_LSB +: 8] = hp_left_gain;
               prdata_nxt[GAIN_R_LSB +: 8] = hp_right_gain;
            end
            default: begin
               prdata_nxt = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_r   <= CTRL_RESET;
         prdata_r <= '0;
      end else begin
         ctrl_r   <= ctrl_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // Boot show: a step divider gives one enable pulse per indicator.
   assign step_en   = step_cnt_r == 32'(BOOT_STEP_CYC - 1);
   assign boot_done = boot_r == BOOT_RUN;

   always_comb begin
      step_cnt_nxt = step_cnt_r;
      boot_nxt     = boot_r;
      if (!boot_done) begin
         step_cnt_nxt = step_en ? '0 : step_cnt_r + 32'h1;
      end
      if (step_en) begin
         case (boot_r)
            BOOT_LED0: boot_nxt = BOOT_LED1; // RL12
            BOOT_LED1: boot_nxt = BOOT_LED2; // RL12
            BOOT_LED2: boot_nxt = BOOT_LED3; // RL12
            BOOT_LED3: boot_nxt = BOOT_RUN; // RL12
            default:   boot_nxt = BOOT_RUN;
         endcase
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         step_cnt_r <= '0;
         boot_r     <= BOOT_LED0;
      end else begin
         step_cnt_r <= step_cnt_nxt;
         boot_r     <= boot_nxt;
      end
   end

   // Main output. It stays muted during the boot show so that nothing
   // reaches air before the panel has finished starting.
   assign talk_any = tb1_active || tb2_active;

   always_comb begin
      main_act_nxt = boot_done && main_request
                     && (system_mode_switch || !talk_any); // RL9 RL11
      main_mute_nxt = !main_act_nxt;
      src_sel_nxt   = main_source_switch; // RL8 RL13
      led_nxt       = boot_leds(boot_r); // RL12
      if (boot_done) begin
         led_nxt[LED_GREEN] = main_act_nxt; // RL10
         led_nxt[LED_RED]   = !system_mode_switch && !main_act_nxt; // RL10
         led_nxt[LED_TB1]   = tb1_active;
         led_nxt[LED_TB2]   = tb2_active;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         main_mute_r <= 1'b1;
         src_sel_r   <= 1'b0;
         led_r       <= '0;
      end else begin
         main_mute_r <= main_mute_nxt;
         src_sel_r   <= src_sel_nxt;
         led_r       <= led_nxt;
      end
   end

   assign main_mute       = main_mute_r;
   assign main_source_sel = src_sel_r;
   assign led_main_red    = led_r[LED_RED];
   assign led_main_green  = led_r[LED_GREEN];
   assign led_tb1         = led_r[LED_TB1];
   assign led_tb2         = led_r[LED_TB2];

   cml_hp_map u_hp_map (
      .clk           (clk),
      .reset         (reset),
      .map_balance   (hp_map_select_switch),
      .side_reverse  (hp_side_reverse_switch),
      .full_mute     (hp_min_level_switch),
      .pot_left      (pot_left_code),
      .pot_right     (pot_right_code),
      .hp_left_gain  (hp_left_gain),
      .hp_right_gain (hp_right_gain),
      .hp_left_mute  (hp_left_mute),
      .hp_right_mute (hp_right_mute)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence s_step_done;
      step_en && !boot_done;
   endsequence

   sequence s_ctrl_write;
      apb_wr_ctrl ##1 1'b1;
   endsequence

   a_source_route: assert property ($changed(main_source_sel) |-> // RL8
      $past(main_source_switch) == main_source_sel)
      else $error("Main source moved without the source switch.");
   a_onair_talk: assert property (boot_done && !system_mode_switch && // RL9
      talk_any |=> main_mute && !led_main_green && led_main_red)
      else $error("Talkback in on-air mode left main open.");
   a_main_leds: assert property (boot_done && $past(boot_done) |-> // RL10
      led_main_green == !main_mute)
      else $error("Green indicator disagrees with main state.");
   a_prod_no_mute: assert property (boot_done && system_mode_switch && // RL11
      main_request |=> !main_mute && !led_main_red)
      else $error("Production mode muted main or lit red.");
   a_boot_onehot: assert property (!boot_done && // RL12
      $past(!boot_done) && !$past(reset) |-> $onehot(led_r))
      else $error("Boot show lit other than one indicator.");
   a_boot_step: assert property (s_step_done |=> // RL12
      boot_r != $past(boot_r))
      else $error("Boot show did not advance on its step.");
   a_boot_hold: assert property (!step_en |=> $stable(boot_r)) // RL12
      else $error("Boot show advanced without a step.");
   a_boot_mute: assert property (!boot_done |=> main_mute) // RL12
      else $error("Main opened during the boot show.");
   a_ctrl_live: assert property (s_ctrl_write |=> // RL13
      main_source_sel == $past(pwdata[CTRL_SRC_BIT], 2))
      else $error("Source switch write did not reach the output.");
   a_unmapped_err: assert property (apb_access && !addr_hit(paddr) |->
      pslverr && pready)
      else $error("Unmapped access not flagged.");
   a_mapped_ok: assert property (apb_access && addr_hit(paddr) |-> !pslverr)
      else $error("Mapped access flagged an error.");
   a_read_hold: assert property (apb_access |=> $stable(prdata))
      else $error("Read data moved after the access.");

   // Register port: only a strobed control write may move the switches.
   a_write_lands: assert property (apb_wr_ctrl |=> // RL13
      ctrl_r == $past(pwdata[CTRL_W-1:0]))
      else $error("Control write did not land.");
   a_strobe_off: assert property (apb_access && pwrite && !pstrb[0] |=>
      $stable(ctrl_r))
      else $error("Control changed without its strobe.");
   a_wr_ignored: assert property (apb_access && pwrite && paddr != ADDR_CTRL
      |=> $stable(ctrl_r))
      else $error("Control changed on a write elsewhere.");

   // Indicators, main mute and source, and the boot show sequencer.
   a_prod_red_off: assert property (boot_done && system_mode_switch |=> // RL11
      !led_main_red)
      else $error("Red indicator lit in production mode.");
   a_onair_red: assert property (boot_done && !system_mode_switch |=> // RL10
      led_main_red == main_mute)
      else $error("Red indicator disagrees with main state.");
   a_tb_leds: assert property (boot_done |=> // RL11
      led_tb1 == $past(tb1_active) && led_tb2 == $past(tb2_active))
      else $error("Talkback indicator missed its function.");
   a_no_req_mute: assert property (boot_done && !main_request |=> main_mute)
      else $error("Main opened without a request.");
   a_src_follow: assert property (1'b1 |=> // RL8 RL13
      main_source_sel == $past(main_source_switch))
      else $error("Main source lags the source switch.");
   a_boot_leds: assert property (!boot_done |=> // RL12
      led_r == boot_leds($past(boot_r)))
      else $error("Boot show lit the wrong indicator.");
   a_boot_stays: assert property (boot_done |=> boot_done) // RL12
      else $error("Boot show restarted while running.");
   a_step_range: assert property (step_cnt_r <= 32'(BOOT_STEP_CYC - 1))
      else $error("Boot step divider overran.");
endmodule : cml_console_ctrl

// >>> cml_panel_model.sv
// Purpose: Front-panel stand-in that drives pot codes and activity levels.
// Assumes: Pots are already digitised; button logic upstream gives levels.
// Notes: Values change only just after a rising edge, as real panel logic.
`timescale 1ns/1ns
module cml_panel_model (
   input  wire logic       clk,
   output logic      [7:0] pot_left_code,
   output logic      [7:0] pot_right_code,
   output logic            main_request,
   output logic            tb1_active,
   output logic            tb2_active
);
   initial begin
      pot_left_code  = 8'h80;
      pot_right_code = 8'h80;
      main_request   = 1'b0;
      tb1_active     = 1'b0;
      tb2_active     = 1'b0;
   end

   // Moving both knobs in one edge is harsher than a hand can manage.
   task automatic set_panel(input logic [7:0] pl, input logic [7:0] pr,
                            input logic mr, input logic t1,
                            input logic t2);
      @(posedge clk);
      pot_left_code  <= pl;
      pot_right_code <= pr;
      main_request   <= mr;
      tb1_active     <= t1;
      tb2_active     <= t2;
   endtask : set_panel
endmodule : cml_panel_model

// >>> cml_console_ctrl_bench.sv
// Purpose: Self-checking bench for the console mode control logic.
// Assumes: A boot step of 4 cycles keeps the run short.
// Notes: Expected values come from the integer model in this file.
`timescale 1ns/1ns
module cml_console_ctrl_bench
   import cml_pkg::*;
;
   localparam int STEP = 4;
   logic        clk;
   logic        reset;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  pot_l;
   logic [7:0]  pot_r;
   logic        req;
   logic        tb1;
   logic        tb2;
   logic [7:0]  hl_g;
   logic [7:0]  hr_g;
   logic        hl_m;
   logic        hr_m;
   logic        src;
   logic        mmute;
   logic        led_r;
   logic        led_g;
   logic        led_t1;
   logic        led_t2;
   int          error_cnt;
   int          total_checks;
   int          exp_gain;
   int          exp_st;
   logic        exp_anymute;
   logic [7:0]  pots [8] = '{8'h00, 8'hff, 8'h80, 8'h81, 8'h7f, 8'h01,
                              8'hfe, 8'h40};

   cml_panel_model i_panel (.clk(clk), .pot_left_code(pot_l),
      .pot_right_code(pot_r), .main_request(req), .tb1_active(tb1),
      .tb2_active(tb2));

   cml_console_ctrl #(.BOOT_STEP_CYC(STEP)) i_dut (.clk(clk),
      .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pot_left_code(pot_l),
      .pot_right_code(pot_r), .main_request(req), .tb1_active(tb1),
      .tb2_active(tb2), .hp_left_gain(hl_g), .hp_right_gain(hr_g),
      .hp_left_mute(hl_m), .hp_right_mute(hr_m),
      .main_source_sel(src), .main_mute(mmute), .led_main_red(led_r),
      .led_main_green(led_g), .led_tb1(led_t1), .led_tb2(led_t2));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen,
                  exp);
      end
   endtask : check

   // Setup, then access held until pready is sampled high.
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         error_cnt++;
         test_done();
      end
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic int scl(int b);
      return (b <= 128) ? 256 : (255 - b) * 2;
   endfunction : scl

   function automatic logic [7:0] pick();
      if ($urandom % 2) return pots[$urandom % 8];
      return 8'($urandom);
   endfunction : pick

   task automatic check_all(input logic [4:0] c, input int pl, input int pr,
                            input logic mr, input logic t1, input logic t2);
      int   gl;
      int   gr;
      int   sl;
      int   sr;
      logic ml;
      logic mt;
      logic act;
      logic red;
      if (!c[CTRL_MAP_BIT]) begin
         gl = c[CTRL_REV_BIT] ? pr : pl;
         gr = c[CTRL_REV_BIT] ? pl : pr;
         ml = (gl == 0);
         mt = (gr == 0);
      end else begin
         sl = c[CTRL_REV_BIT] ? scl(255 - pr) : scl(pr);
         sr = c[CTRL_REV_BIT] ? scl(pr) : scl(255 - pr);
         gl = (pl * sl) >> 8;
         gr = (pl * sr) >> 8;
         ml = (pl == 0) || (sl == 0);
         mt = (pl == 0) || (sr == 0);
      end
      if (!c[CTRL_MIN_BIT]) begin
         ml = 1'b0;
         mt = 1'b0;
         if (gl < GAIN_FLOOR) gl = GAIN_FLOOR;
         if (gr < GAIN_FLOOR) gr = GAIN_FLOOR;
      end
      act = mr && (c[CTRL_SYS_BIT] || !(t1 || t2));
      red = !c[CTRL_SYS_BIT] && !act;
      check(32'(hl_m), 32'(ml));
      check(32'(hr_m), 32'(mt));
      // A muted channel's gain code is left open, so it is not compared.
      if (!ml) check(32'(hl_g), 32'(gl));
      if (!mt) check(32'(hr_g), 32'(gr));
      check(32'(src), 32'(c[CTRL_SRC_BIT]));
      check(32'(mmute), 32'(!act));
      check(32'({led_t2, led_t1, led_g, led_r}),
            32'({t2, t1, act, red}));
      exp_anymute = ml || mt;
      exp_gain    = (gr << 8) | gl;
      exp_st      = {t2, t1, act, red, 1'b1, act, mt, ml};
   endtask : check_all

   initial begin
      repeat (60000) @(posedge clk);
      error_cnt++;
      $display("watchdog expired");
      test_done();
   end

   initial begin
      logic [31:0] rd;
      logic        err;
      logic [3:0]  v;
      logic [3:0]  last;
      logic [7:0]  pl;
      logic [7:0]  pr;
      logic [31:0] r;
      logic [3:0]  runs [$];
      int          lens [$];
      error_cnt    = 0;
      total_checks = 0;
      reset   = 1'b1;
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h0;
      pstrb   = 4'h0;
      last    = 4'h0;
      void'($urandom(40632));
      i_panel.set_panel(8'h80, 8'h80, 1'b1, 1'b0, 1'b0);
      @(posedge clk);
      reset <= 1'b0;
      for (int i = 0; i < 24; i++) begin
         @(posedge clk);
         #1;
         v = {led_t2, led_t1, led_g, led_r};
         if (i < 4 * STEP - 1) check(32'(mmute), 32'h1);
         if (i == 0 || v !== last) begin
            runs.push_back(v);
            lens.push_back(1);
         end else begin
            lens[$]++;
         end
         last = v;
      end
      for (int i = 0; i < 4; i++) begin
         check(32'(runs[i]), 32'(1 << i));
         check(32'(lens[i]), 32'(STEP));
      end
      $display("boot show test done");
      // Switches change while running, never with a reset between.
      for (int c = 0; c < 32; c++) begin
         apb(1'b1, ADDR_CTRL, 32'(c), 4'hf, rd, err);
         for (int k = 0; k < 8; k++) begin
            pl = pick();
            pr = pick();
            r  = $urandom;
            i_panel.set_panel(pl, pr, r[0], r[1], r[2]);
            @(posedge clk);
            #1;
            check_all(5'(c), int'(pl), int'(pr), r[0], r[1], r[2]);
         end
         apb(1'b0, ADDR_CTRL, 32'h0, 4'h0, rd, err);
         check(rd, 32'(c));
         apb(1'b0, ADDR_STATUS, 32'h0, 4'h0, rd, err);
         check(rd, 32'(exp_st));
         apb(1'b0, ADDR_GAIN, 32'h0, 4'h0, rd, err);
         if (!exp_anymute) check(rd, 32'(exp_gain));
         $display("switch setting %h test done", c);
      end
      apb(1'b1, 12'h010, 32'h1f, 4'hf, rd, err);
      check(32'(err), 32'h1);
      apb(1'b0, 12'h010, 32'h0, 4'h0, rd, err);
      check(32'(err), 32'h1);
      check(rd, 32'h0);
      apb(1'b1, ADDR_STATUS, 32'h1f, 4'hf, rd, err);
      check(32'(err), 32'h0);
      apb(1'b1, ADDR_CTRL, 32'h00, 4'h0, rd, err);
      apb(1'b0, ADDR_CTRL, 32'h0, 4'h0, rd, err);
      check(rd, 32'h1f);
      $display("refused access test done");
      test_done();
   end
endmodule : cml_console_ctrl_bench
